/* rtl/ssc_serial_regs.sv */
// Serial-loaded configuration register bank with double-buffered commit
`default_nettype none
module ssc_serial_regs
	import ssc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic latch_strobe,
	output logic [ssc_pkg::SSC_INT_W-1:0] int_value,
	output logic [ssc_pkg::SSC_FRACTION_NUMERATOR_W-1:0] fraction_numerator,
	output logic [ssc_pkg::SSC_MOD_W-1:0] fraction_modulus,
	output logic [ssc_pkg::SSC_PHASE_W-1:0] phase_word,
	output logic prescaler_select,
	output logic phase_adjust_enable,
	output logic [ssc_pkg::SSC_WORD_W-1:0] modulus_phase_word,
	output logic [ssc_pkg::SSC_WORD_W-1:0] reference_function_word,
	output logic [ssc_pkg::SSC_WORD_W-1:0] clock_divider_word,
	output logic [ssc_pkg::SSC_WORD_W-1:0] fixed_config_word,
	output logic [ssc_pkg::SSC_WORD_W-1:0] lock_pin_mode_word,
	output logic [ssc_pkg::SSC_RCNT_W-1:0] ref_count,
	output logic reference_doubler,
	output logic reference_halving,
	output logic [ssc_pkg::SSC_CP_W-1:0] pump_current,
	output logic commit_pulse
);
	import ssc_pkg::*;

	// Serial side: link clock domain, no reset since it only runs during frames
	logic [SSC_WORD_W-1:0] shift_reg;
	always_ff @(posedge serial_clk) begin
		shift_reg <= {shift_reg[SSC_WORD_W-2:0], serial_data};
	end

	shift_msb_first_a: assert property (@(posedge serial_clk)
		1'b1 ##1 1'b1
		|=> shift_reg[1:0] == {$past(serial_data, 2), $past(serial_data)})
		else $error("serial bits not shifted in order");

	// Strobe crossing: three stages, change counted when second and third agree
	logic [2:0] le_sync_reg;
	logic le_level_reg;
	logic le_rise;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			le_sync_reg <= 3'h0;
			le_level_reg <= 1'b0;
		end else begin
			le_sync_reg <= {le_sync_reg[1:0], latch_strobe};
			if (le_sync_reg[1] == le_sync_reg[2]) begin
				le_level_reg <= le_sync_reg[2];
			end
		end
	end
	assign le_rise = (le_sync_reg[1] == le_sync_reg[2]) && le_sync_reg[2] && !le_level_reg;

	rise_to_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!le_level_reg && le_sync_reg[2:1] == 2'b11
		|=> load_reg)
		else $error("agreed strobe rise did not load");
	fall_track_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		le_sync_reg[2:1] == 2'b00
		|=> !le_level_reg)
		else $error("strobe release not tracked");

	// The host holds serial clock still while the strobe is high, so the word is stable
	// when sampled here; a word-wide synchroniser would add nothing.
	logic [SSC_WORD_W-1:0] word_sample_reg;
	logic load_reg;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			word_sample_reg <= SSC_WORD_RST;
			load_reg <= 1'b0;
		end else begin
			load_reg <= le_rise;
			if (le_rise) begin
				word_sample_reg <= shift_reg;
			end
		end
	end

	sample_take_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		le_rise
		|=> load_reg && word_sample_reg == $past(shift_reg))
		else $error("word not sampled on strobe rise");
	sample_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!le_rise
		|=> !load_reg && $stable(word_sample_reg))
		else $error("word sample moved without strobe rise");
	load_single_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		load_reg
		|=> !load_reg)
		else $error("load lasted more than one cycle");

	function automatic logic [SSC_SEL_W-1:0] sel_of(input logic [SSC_WORD_W-1:0] w);
		sel_of = w[SSC_SEL_LSB +: SSC_SEL_W];
	endfunction : sel_of

	// Six latches written by select code; codes six and seven are ignored
	logic [SSC_WORD_W-1:0] latch_reg [SSC_NREG];
	genvar gi;
	generate
		for (gi = 0; gi < SSC_NREG; gi++) begin : g_latch
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					latch_reg[gi] <= SSC_WORD_RST;
				end else if (load_reg && sel_of(word_sample_reg) == SSC_SEL_W'(gi)) begin
					latch_reg[gi] <= word_sample_reg;
				end
			end
			latch_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
				load_reg && word_sample_reg[2:0] == gi
				|=> latch_reg[gi] == $past(word_sample_reg))
				else $error("latch not loaded from its select code");
			latch_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
				!(load_reg && word_sample_reg[2:0] == gi)
				|=> $stable(latch_reg[gi]))
				else $error("latch changed without its select code");
		end
	endgenerate

	logic freq_write;
	assign freq_write = load_reg && sel_of(word_sample_reg) == SSC_SEL_FREQ;

	// Frequency word fields apply directly
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			int_value <= '0;
			fraction_numerator <= '0;
		end else if (freq_write) begin
			int_value <= word_sample_reg[SSC_INT_LSB +: SSC_INT_W];
			fraction_numerator <= word_sample_reg[SSC_FRACTION_NUMERATOR_LSB +: SSC_FRACTION_NUMERATOR_W];
		end
	end
	int_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!freq_write
		|=> $stable(int_value) && $stable(fraction_numerator))
		else $error("frequency word fields changed without a write");

	// Prescaler and phase adjust are not buffered, so they act as soon as they are latched
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prescaler_select <= 1'b0;
			phase_adjust_enable <= 1'b0;
		end else if (load_reg && sel_of(word_sample_reg) == SSC_SEL_MODPH) begin
			prescaler_select <= word_sample_reg[SSC_PRESC_BIT];
			phase_adjust_enable <= word_sample_reg[SSC_PHADJ_BIT];
		end
	end
	presc_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		load_reg && word_sample_reg[2:0] == 3'h1
		|=> prescaler_select == $past(word_sample_reg[27])
			&& phase_adjust_enable == $past(word_sample_reg[28]))
		else $error("prescaler bits not taken");
	presc_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(load_reg && word_sample_reg[2:0] == 3'h1)
		|=> $stable(prescaler_select) && $stable(phase_adjust_enable))
		else $error("prescaler bits changed without a write");

	// Commit strobe for the loop logic, high in the same cycle that the buffered fields have moved
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			commit_pulse <= 1'b0;
		end else begin
			commit_pulse <= freq_write;
		end
	end
	commit_only_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!freq_write
		|=> !commit_pulse)
		else $error("commit pulse without a frequency word write");
	commit_after_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		le_rise && shift_reg[2:0] == 3'h0
		|-> ##2 commit_pulse)
		else $error("commit pulse late after latch strobe");

	// Active copies of double-buffered fields, refreshed only by a frequency word write
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fraction_modulus <= '0;
			phase_word <= '0;
		end else if (freq_write) begin
			fraction_modulus <= latch_reg[SSC_SEL_MODPH][SSC_MOD_LSB +: SSC_MOD_W];
			phase_word <= latch_reg[SSC_SEL_MODPH][SSC_PHASE_LSB +: SSC_PHASE_W];
		end
	end
	phase_commit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write
		|=> phase_word == $past(latch_reg[1][26:15]))
		else $error("phase word not committed");
	modph_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		load_reg && word_sample_reg[2:0] == 3'h1
		|=> $stable(fraction_modulus) && $stable(phase_word))
		else $error("modulus applied before commit");

	// Reference settings wait for the same commit, so a half-written setup never shows
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ref_count <= '0;
			reference_doubler <= 1'b0;
			reference_halving <= 1'b0;
			pump_current <= '0;
		end else if (freq_write) begin
			ref_count <= latch_reg[SSC_SEL_REFF][SSC_RCNT_LSB +: SSC_RCNT_W];
			reference_doubler <= latch_reg[SSC_SEL_REFF][SSC_RDBL_BIT];
			reference_halving <= latch_reg[SSC_SEL_REFF][SSC_RHALF_BIT];
			pump_current <= latch_reg[SSC_SEL_REFF][SSC_CP_LSB +: SSC_CP_W];
		end
	end
	rcount_commit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write
		|=> ref_count == $past(latch_reg[2][23:14]))
		else $error("reference count not committed");
	ref_bits_commit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write
		|=> reference_doubler == $past(latch_reg[2][25])
			&& reference_halving == $past(latch_reg[2][24]))
		else $error("reference doubler or halving not committed");
	pump_commit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write
		|=> pump_current == $past(latch_reg[2][12:9]))
		else $error("pump current not committed");
	ref_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		load_reg && word_sample_reg[2:0] == 3'h2
		|=> $stable(ref_count) && $stable(reference_doubler)
			&& $stable(reference_halving) && $stable(pump_current))
		else $error("reference settings applied before commit");
	buffer_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!freq_write
		|=> $stable(phase_word) && $stable(reference_doubler)
			&& $stable(reference_halving) && $stable(pump_current))
		else $error("buffered setting changed without commit");

	// Raw latch images for the remaining functions
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			modulus_phase_word <= SSC_WORD_RST;
			reference_function_word <= SSC_WORD_RST;
			clock_divider_word <= SSC_WORD_RST;
			fixed_config_word <= SSC_WORD_RST;
			lock_pin_mode_word <= SSC_WORD_RST;
		end else begin
			modulus_phase_word <= latch_reg[SSC_SEL_MODPH];
			reference_function_word <= latch_reg[SSC_SEL_REFF];
			clock_divider_word <= latch_reg[SSC_SEL_CLKDIV];
			fixed_config_word <= latch_reg[SSC_SEL_FIXED];
			lock_pin_mode_word <= latch_reg[SSC_SEL_LOCKPIN];
		end
	end

	raw_image_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		1'b1
		|=> modulus_phase_word == $past(latch_reg[1])
			&& reference_function_word == $past(latch_reg[2])
			&& clock_divider_word == $past(latch_reg[3])
			&& fixed_config_word == $past(latch_reg[4])
			&& lock_pin_mode_word == $past(latch_reg[5]))
		else $error("raw register image does not follow its latch");

	// Assertions
	freq_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write |=> latch_reg[0] == $past(word_sample_reg))
		else $error("frequency latch not loaded");
	modph_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		load_reg && word_sample_reg[2:0] == 3'h1 |=> latch_reg[1] == $past(word_sample_reg))
		else $error("modulus latch not loaded");
	int_field_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write |=> int_value == $past(word_sample_reg[30:15]))
		else $error("integer field wrong");
	fraction_numerator_field_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write |=> fraction_numerator == $past(word_sample_reg[14:3]))
		else $error("fraction field wrong");
	modulus_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!freq_write |=> $stable(fraction_modulus) && $stable(ref_count))
		else $error("buffered field changed without commit");
	commit_copy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write |=> fraction_modulus == $past(latch_reg[1][14:3]))
		else $error("modulus not committed");
	load_follow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		le_rise |=> load_reg ##1 !load_reg)
		else $error("load pulse wrong");
	sel_route_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		load_reg && word_sample_reg[2:0] == 3'h4 |=> $stable(latch_reg[0]) && $stable(latch_reg[1]))
		else $error("write routed to wrong latch");
	commit_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		freq_write |=> commit_pulse ##1 !commit_pulse)
		else $error("commit pulse wrong");
endmodule : ssc_serial_regs
`default_nettype wire

/* rtl/ssc_pkg.sv */
// Constants for the synthesizer serial configuration register bank
`default_nettype none
package ssc_pkg;
	localparam int SSC_WORD_W = 32;
	localparam int SSC_SEL_W = 3;
	localparam int SSC_INT_W = 16;
	localparam int SSC_FRACTION_NUMERATOR_W = 12;
	localparam int SSC_NREG = 6;
	localparam logic [2:0] SSC_SEL_FREQ = 3'h0;
	localparam logic [2:0] SSC_SEL_MODPH = 3'h1;
	localparam logic [2:0] SSC_SEL_REFF = 3'h2;
	localparam logic [2:0] SSC_SEL_CLKDIV = 3'h3;
	localparam logic [2:0] SSC_SEL_FIXED = 3'h4;
	localparam logic [2:0] SSC_SEL_LOCKPIN = 3'h5;
	localparam int SSC_SEL_LSB = 0;
	localparam int SSC_FRACTION_NUMERATOR_LSB = 3;
	localparam int SSC_INT_LSB = 15;
	localparam int SSC_MOD_LSB = 3;
	localparam int SSC_MOD_W = 12;
	localparam int SSC_PHASE_LSB = 15;
	localparam int SSC_PHASE_W = 12;
	localparam int SSC_PRESC_BIT = 27;
	localparam int SSC_PHADJ_BIT = 28;
	localparam int SSC_CP_LSB = 9;
	localparam int SSC_CP_W = 4;
	localparam int SSC_RCNT_LSB = 14;
	localparam int SSC_RCNT_W = 10;
	localparam int SSC_RHALF_BIT = 24;
	localparam int SSC_RDBL_BIT = 25;
	localparam logic [31:0] SSC_WORD_RST = 32'h0000_0000;
endpackage : ssc_pkg
`default_nettype wire

/* sim/ssc_host_model.sv */
// Host model driving the three-wire serial link
`default_nettype none
module ssc_host_model (
	output logic serial_clk,
	output logic serial_data,
	output logic latch_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
	end
	// Link clock stands still between frames; data flips so a stale bit never looks valid
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			serial_data = w[i];
			#80 serial_clk = 1'b1;
			#80 serial_clk = 1'b0;
		end
		serial_data = ~w[0];
		#200 latch_strobe = 1'b1;
		#100 latch_strobe = 1'b0;
		#200;
	endtask : send
endmodule : ssc_host_model
`default_nettype wire

/* sim/ssc_serial_regs_bench.sv */
// Self-checking bench for the serial configuration register bank
`default_nettype none
module ssc_serial_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk;
	logic sys_rst;
	wire logic serial_clk, serial_data, latch_strobe;
	logic [15:0] int_value;
	logic [11:0] fraction_numerator, fraction_modulus, phase_word;
	logic prescaler_select, phase_adjust_enable, reference_doubler, reference_halving;
	logic [31:0] modulus_phase_word, reference_function_word, clock_divider_word;
	logic [31:0] fixed_config_word, lock_pin_mode_word;
	logic [9:0] ref_count;
	logic [3:0] pump_current;
	logic commit_pulse;
	wire logic [67:0] fields;
	logic [67:0] cur = '0;
	logic [67:0] exp_q[$];
	logic [31:0] raw [1:5] = '{default: '0};
	logic [31:0] r = 32'ha9313142;
	int num_errors = 0;
	int num_checks = 0;
	assign fields = {int_value, fraction_numerator, fraction_modulus, phase_word, ref_count,
		reference_doubler, reference_halving, pump_current};
	ssc_host_model HOST (.serial_clk(serial_clk), .serial_data(serial_data),
		.latch_strobe(latch_strobe));
	ssc_serial_regs DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
		.serial_data(serial_data), .latch_strobe(latch_strobe), .int_value(int_value),
		.fraction_numerator(fraction_numerator), .fraction_modulus(fraction_modulus),
		.phase_word(phase_word), .prescaler_select(prescaler_select),
		.phase_adjust_enable(phase_adjust_enable), .modulus_phase_word(modulus_phase_word),
		.reference_function_word(reference_function_word),
		.clock_divider_word(clock_divider_word), .fixed_config_word(fixed_config_word),
		.lock_pin_mode_word(lock_pin_mode_word), .ref_count(ref_count),
		.reference_doubler(reference_doubler), .reference_halving(reference_halving),
		.pump_current(pump_current), .commit_pulse(commit_pulse));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic test_done();
		if (num_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [159:0] seen, input logic [159:0] want, input string what);
		num_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, want, seen);
		end
	endtask : chk
	// Note is queued before sending, since the commit pulse appears while the frame ends
	task automatic wr(input logic [2:0] sel, input logic [28:0] body);
		logic [31:0] w;
		w = {body, sel};
		if (sel == 3'h0) begin
			cur = {w[30:15], w[14:3], raw[1][14:3], raw[1][26:15], raw[2][23:14], raw[2][25],
				raw[2][24], raw[2][12:9]};
			exp_q.push_back(cur);
		end else if (sel < 3'h6) begin
			raw[sel] = w;
		end
		HOST.send(w);
		chk(fields, cur, "fields");
		chk({modulus_phase_word, reference_function_word, clock_divider_word, fixed_config_word,
			lock_pin_mode_word}, {raw[1], raw[2], raw[3], raw[4], raw[5]}, "raw");
		chk({prescaler_select, phase_adjust_enable}, {raw[1][27], raw[1][28]}, "presc");
	endtask : wr
	always @(posedge ref_clk) begin
		if (commit_pulse === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(0, 1, "commit_pulse");
			end else begin
				chk(fields, exp_q.pop_front(), "commit");
			end
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#400us;
		num_errors++;
		test_done();
	end
	initial begin
		logic [11:0] m;
		sys_rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(fields, 68'h0, "reset");
		for (int k = 0; k < 3; k++) begin
			r = lfsr(lfsr(r));
			m = 12'(2 + r % 4094);
			wr(3'h1, {3'h0, r[20], 1'b1, 12'(r % m), m});
			r = lfsr(lfsr(r));
			wr(3'h2, {1'b0, r[27:11], 1'b0, r[9:0]});
			r = lfsr(lfsr(r));
			wr(3'h0, {1'b0, 16'(75 + r % 32693), 12'(r[31:8] % m)});
		end
		// Codes three to five load their own latches; refused codes six and seven must leave every latch alone
		for (int s = 3; s < 8; s++) begin
			r = lfsr(lfsr(r));
			wr(3'(s), (s == 4) ? 29'h100000 : r[28:0] & ((s == 5) ? 29'h180000 : 29'hcbfff));
		end
		wr(3'h0, {1'b0, 16'd75, 12'h0});
		chk(32'(exp_q.size()), 0, "queue");
		test_done();
	end
endmodule : ssc_serial_regs_bench
`default_nettype wire
